//--- hdl/brd_pkg.sv
// Package: register map, field layout and reset values of the boot ROM decoder
`default_nettype none
package brd_pkg;
	localparam logic [11:0] OFF_BASE_LOW  = 12'h030;
	localparam logic [11:0] OFF_BASE_HIGH = 12'h032;
	localparam logic [11:0] OFF_MASK_LOW  = 12'h034;
	localparam logic [11:0] OFF_MASK_HIGH = 12'h036;
	localparam logic [11:0] OFF_CONTROL   = 12'h040;
	localparam logic [11:0] OFF_STATUS    = 12'h044;
	localparam int          SA_WIDTH      = 20;
	localparam int          IGNORE_BITS   = 12;
	localparam logic [15:0] RESET_WORD    = 16'h0000;
	localparam int          LOADED_BITS   = 4;
	localparam int          CTRL_GENOUT   = 0;
	localparam int          STAT_LOADED   = 0;
	localparam int          STAT_LINK     = 1;
	localparam int          STAT_ACT      = 2;
endpackage
`default_nettype wire

//--- hdl/brd_if.sv
// Interface: loaded base and mask carried to the address comparator
`default_nettype none
interface brd_match_if;
	logic [31:0] base;
	logic [31:0] mask;
	logic        enable;
	logic        hit;
	modport regs (output base, output mask, output enable, input hit);
	modport cmp  (input base, input mask, input enable, output hit);
endinterface
`default_nettype wire

//--- hdl/brd_compare.sv
// Address comparator for the boot ROM window
`default_nettype none
module brd_compare (
	brd_match_if.cmp     m,
	input  wire logic [19:0] sa
);
	// ---------------------------------------------------------------
	// Compare
	// ---------------------------------------------------------------
	// Low 12 mask bits forced to zero so sizes step by 4K
	wire logic [19:0] eff_mask;
	wire logic [19:0] diff;
	assign eff_mask = {m.mask[19:brd_pkg::IGNORE_BITS], {brd_pkg::IGNORE_BITS{1'b0}}};
	assign diff     = (sa ^ m.base[19:0]) & eff_mask;
	assign m.hit    = m.enable && (diff == 20'h00000);
endmodule
`default_nettype wire

//--- hdl/brd_top.sv
// Boot ROM decode, indicator drive and general output with APB registers
//
// Design decision made here: the APB interface to the registers.
`default_nettype none
module brd_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [19:0] sa,
	input  wire logic        link_pulse_det,
	input  wire logic        tx_active,
	input  wire logic        rx_active,
	input  wire logic        collision,
	output logic             boot_rom_select_n,
	output logic             link_indicator_n,
	output logic             activity_indicator_n,
	output logic             general_output_1
);
	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	// Each 16-bit register takes its own aligned word; 30h/32h etc. are not all
	// word multiples, so they serve as indices and the byte address is index times four
	wire logic        wr_en;
	wire logic        hit_bl;
	wire logic        hit_bh;
	wire logic        hit_ml;
	wire logic        hit_mh;
	wire logic        hit_ct;
	wire logic        hit_st;
	wire logic        mapped;
	wire logic [15:0] wdata16;
	assign wr_en   = psel && penable && pwrite;
	assign hit_bl  = paddr == {brd_pkg::OFF_BASE_LOW[9:0], 2'b00};
	assign hit_bh  = paddr == {brd_pkg::OFF_BASE_HIGH[9:0], 2'b00};
	assign hit_ml  = paddr == {brd_pkg::OFF_MASK_LOW[9:0], 2'b00};
	assign hit_mh  = paddr == {brd_pkg::OFF_MASK_HIGH[9:0], 2'b00};
	assign hit_ct  = paddr == {brd_pkg::OFF_CONTROL[9:0], 2'b00};
	assign hit_st  = paddr == {brd_pkg::OFF_STATUS[9:0], 2'b00};
	assign mapped  = hit_bl | hit_bh | hit_ml | hit_mh | hit_ct | hit_st;
	assign wdata16 = pwdata[15:0];
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [15:0] base_low_reg;
	logic [15:0] base_high_reg;
	logic [15:0] mask_low_reg;
	logic [15:0] mask_high_reg;
	logic [3:0]  loaded_reg;
	logic        genout_reg;
	wire logic [3:0] wr_hit;
	wire logic       all_loaded;
	assign wr_hit     = {hit_mh, hit_ml, hit_bh, hit_bl} & {4{wr_en && pstrb[0] && pstrb[1]}};
	assign all_loaded = &loaded_reg;

	// Byte strobes: partial writes of a halfword are ignored entirely
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_low_reg  <= brd_pkg::RESET_WORD;
			base_high_reg <= brd_pkg::RESET_WORD;
			mask_low_reg  <= brd_pkg::RESET_WORD;
			mask_high_reg <= brd_pkg::RESET_WORD;
		end else begin
			if (wr_hit[0]) base_low_reg  <= wdata16;
			if (wr_hit[1]) base_high_reg <= wdata16;
			if (wr_hit[2]) mask_low_reg  <= wdata16;
			if (wr_hit[3]) mask_high_reg <= wdata16;
		end
	end

	// Loaded flags, one per word, sticky until reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded_reg <= 4'h0;
		end else begin
			loaded_reg <= loaded_reg | wr_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			genout_reg <= 1'b0;
		end else if (wr_en && hit_ct && pstrb[0]) begin
			genout_reg <= pwdata[brd_pkg::CTRL_GENOUT];
		end
	end

	// ---------------------------------------------------------------
	// Indicator inputs
	// ---------------------------------------------------------------
	// Media status comes from another domain: two flops before use
	logic [3:0] ind_s1_reg;
	logic [3:0] ind_s2_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ind_s1_reg <= 4'h0;
			ind_s2_reg <= 4'h0;
		end else begin
			ind_s1_reg <= {collision, rx_active, tx_active, link_pulse_det};
			ind_s2_reg <= ind_s1_reg;
		end
	end
	wire logic link_now;
	wire logic act_now;
	assign link_now = ind_s2_reg[0];
	assign act_now  = |ind_s2_reg[3:1];

	logic link_n_reg;
	logic act_n_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_n_reg <= 1'b1;
			act_n_reg  <= 1'b1;
		end else begin
			link_n_reg <= !link_now;
			act_n_reg  <= !act_now;
		end
	end
	assign link_indicator_n     = link_n_reg;
	assign activity_indicator_n = act_n_reg;
	assign general_output_1     = genout_reg;

	// ---------------------------------------------------------------
	// Boot ROM decode
	// ---------------------------------------------------------------
	// Address pins are asynchronous to pclk, so they are synchronised;
	// the select therefore lags the bus address by three clocks
	logic [19:0] sa_s1_reg;
	logic [19:0] sa_s2_reg;
	logic        sel_n_reg;
	brd_match_if m ();
	assign m.base   = {base_high_reg, base_low_reg};
	assign m.mask   = {mask_high_reg, mask_low_reg};
	assign m.enable = all_loaded;

	brd_compare u_cmp (
		.m  (m.cmp),
		.sa (sa_s2_reg)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sa_s1_reg <= 20'h00000;
			sa_s2_reg <= 20'h00000;
			sel_n_reg <= 1'b1;
		end else begin
			sa_s1_reg <= sa;
			sa_s2_reg <= sa_s1_reg;
			sel_n_reg <= !m.hit;
		end
	end
	assign boot_rom_select_n = sel_n_reg;

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	wire logic [15:0] rd16;
	wire logic [15:0] status16;
	assign status16 = {13'h0000, act_now, link_now, all_loaded};
	assign rd16 = hit_bl ? base_low_reg  :
	              hit_bh ? base_high_reg :
	              hit_ml ? mask_low_reg  :
	              hit_mh ? mask_high_reg :
	              hit_ct ? {15'h0000, genout_reg} :
	              hit_st ? status16 : 16'h0000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= {16'h0000, rd16};
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_NO_DECODE_UNLOADED: assert property (@(posedge pclk) disable iff (!presetn)
		!all_loaded |=> boot_rom_select_n) else $error("select asserted before load");
	AST_MISMATCH_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
		((sa_s2_reg[19:12] ^ {base_high_reg[3:0], base_low_reg[15:12]}) &
		 {mask_high_reg[3:0], mask_low_reg[15:12]}) != 8'h00 |=> boot_rom_select_n)
		else $error("select on mismatch");
	AST_MATCH_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		all_loaded && ((sa_s2_reg[19:12] ^ {base_high_reg[3:0], base_low_reg[15:12]}) &
		 {mask_high_reg[3:0], mask_low_reg[15:12]}) == 8'h00 |=> !boot_rom_select_n)
		else $error("no select on match");
	AST_SA_PIPE: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |-> ##2 sa_s2_reg == $past(sa, 2)) else $error("address pipe broken");
	AST_BASE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_hit[0] |=> base_low_reg == $past(wdata16)) else $error("base low not written");
	AST_MASK_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_hit[3] |=> mask_high_reg == $past(wdata16) && loaded_reg[3])
		else $error("mask high not written");
	AST_LINK: assert property (@(posedge pclk) disable iff (!presetn)
		link_pulse_det [*3] |=> !link_indicator_n) else $error("link indicator off");
	AST_ACT: assert property (@(posedge pclk) disable iff (!presetn)
		(!tx_active && !rx_active && !collision) [*4] |=> activity_indicator_n)
		else $error("activity without cause");
	AST_GENOUT: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit_ct && pstrb[0] |=> general_output_1 == $past(pwdata[0]))
		else $error("general output not updated");
endmodule
`default_nettype wire

//--- sim/brd_host_model.sv
// Host-side model: ISA address lines and media status toward the decoder
`default_nettype none
module brd_host_model (
	input  wire logic        pclk,
	input  wire logic [19:0] addr_req,
	input  wire logic [3:0]  event_req,
	output logic      [19:0] sa,
	output logic             link_pulse_det,
	output logic             tx_active,
	output logic             rx_active,
	output logic             collision
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Bus and media drive
	// ----------------------------------------
	// The host drives all 20 address lines every cycle, so there is no released state
	always_ff @(posedge pclk) begin
		sa             <= addr_req;
		link_pulse_det <= event_req[0];
		tx_active      <= event_req[1];
		rx_active      <= event_req[2];
		collision      <= event_req[3];
	end
endmodule
`default_nettype wire

//--- sim/brd_top_tb.sv
// Testbench: register access, boot ROM decode, indicators and general output
`default_nettype none
module brd_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [19:0] PROBE [5] = '{20'hD0000, 20'hD3FFF, 20'hD4000, 20'hCFFFF, 20'h50000};
	localparam logic [4:0]  MISS      = 5'h1C;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, event_req;
	logic [19:0] sa, addr_req;
	logic        link_pulse_det, tx_active, rx_active, collision;
	logic        boot_rom_select_n, link_indicator_n, activity_indicator_n, general_output_1;
	int          miscompares = 0;
	int          checks_done = 0;
	int          cycles      = 0;

	brd_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .sa, .link_pulse_det, .tx_active, .rx_active, .collision,
		.boot_rom_select_n, .link_indicator_n, .activity_indicator_n, .general_output_1);
	brd_host_model model (.pclk, .addr_req, .event_req, .sa, .link_pulse_det, .tx_active,
		.rx_active, .collision);

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [11:0] wa(input logic [11:0] off);
		wa = {off[9:0], 2'b00};
	endfunction

	task automatic finish_test();
		if (miscompares == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk_word(what, exp, rd);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	// Hang guard, far above the roughly 110 cycles the sequence needs
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		addr_req = 20'hD0000;
		event_req = 4'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		settle(1);
		chk_bit("select", 1'b1, boot_rom_select_n);
		chk_bit("genout", 1'b0, general_output_1);
		apb(1'b1, wa(brd_pkg::OFF_BASE_LOW), 32'h0);
		apb(1'b1, wa(brd_pkg::OFF_BASE_HIGH), 32'h0000000D);
		apb(1'b1, wa(brd_pkg::OFF_MASK_LOW), 32'h0000C000);
		settle(5);
		chk_bit("select", 1'b1, boot_rom_select_n);
		rdc("status", wa(brd_pkg::OFF_STATUS), 32'h0);
		chk_bit("slverr", 1'b0, err);
		apb(1'b1, wa(brd_pkg::OFF_MASK_HIGH), 32'h0000000F);
		rdc("mask_high", wa(brd_pkg::OFF_MASK_HIGH), 32'h0000000F);
		rdc("base_high", wa(brd_pkg::OFF_BASE_HIGH), 32'h0000000D);
		rdc("status", wa(brd_pkg::OFF_STATUS), 32'h1);
		for (int i = 0; i < 5; i++) begin
			@(posedge pclk);
			addr_req <= PROBE[i];
			settle(5);
			chk_bit("select", MISS[i], boot_rom_select_n);
		end
		for (int i = 0; i < 5; i++) begin
			@(posedge pclk);
			event_req <= (i < 4) ? 4'h1 << i : 4'h0;
			settle(5);
			chk_bit("link", i != 0, link_indicator_n);
			chk_bit("activity", i == 0 || i == 4, activity_indicator_n);
		end
		apb(1'b1, wa(brd_pkg::OFF_CONTROL), 32'h1);
		settle(2);
		chk_bit("genout", 1'b1, general_output_1);
		apb(1'b1, wa(brd_pkg::OFF_CONTROL), 32'h0);
		settle(2);
		chk_bit("genout", 1'b0, general_output_1);
		// Unmapped access must be refused and read as zero
		apb(1'b0, 12'h0FC, 32'h0);
		chk_bit("slverr", 1'b1, err);
		chk_word("unmapped", 32'h0, rd);
		finish_test();
	end
endmodule
`default_nettype wire
